// ==== hdl/can_irq_pkg.sv ====
// Package: register map, types and timing of the CAN irq/power block
//
// Overview of operation
// - Four irq outputs from eleven flag sources, each with its own enable.
// - Empty flag per unscheduled transmit buffer; enabled ones raise transmit irq.
// - Receive-full flag and receive irq set after good frame reaches foreground.
// - Wakeup irq on bus activity in sleep or power-down if ack and enable.
// - Receiver and transmitter warning flags set when error counters reach 96.
// - Counter above 127 sets the matching error-passive flag.
// - Transmit counter above 255 sets the bus-off flag.
// - Each irq stays asserted while any of its enabled flags is set.
// - Write one clears a flag; ignored while its condition still holds.
// - Error counters are read-only; software cannot alter them.
// - Config, timing and acceptance registers writable only in soft reset.
// - Transmit pin forced recessive in every low-power mode.
// - Stop means power-down; else ack/soft-reset pick sleep, soft reset, normal.
// - Sleep entered at once if idle, after pending sends or current frame.
// - Asleep: acknowledge held set, core clocks stopped, register access kept.
// - Bus-off recovery count of 128 by 11 bits paused while asleep.
// - In sleep buffers stay accessible; copies and sends wait for wakeup.
// - Sleep left on bus activity, request cleared, or soft reset set.
// - Clearing the sleep request is ignored until acknowledge reads one.
// - After wakeup wait for the idle count, frozen in sleep, to reach 11 recessive bits before joining the bus.
// - Soft reset halts all ongoing transmit and receive at once.
// - Power-down halts transfers, stops clocks, blocks register access.
package can_irq_pkg;
  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] RFLG_ADDR = 8'h04;
  localparam logic [7:0] RIEN_ADDR = 8'h05;
  localparam logic [7:0] TFLG_ADDR = 8'h06;
  localparam logic [7:0] TIEN_ADDR = 8'h07;
  localparam logic [7:0] STAT_ADDR = 8'h08;
  localparam logic [7:0] RXERR_ADDR = 8'h0e;
  localparam logic [7:0] TXERR_ADDR = 8'h0f;
  localparam logic [7:0] CFG_BASE = 8'h10;
  localparam int CFG_NUM = 12;
  // Control register fields
  localparam int SREQ_BIT = 0;
  localparam int SOFT_BIT = 1;
  localparam int SACK_BIT = 2;
  localparam int WUEN_BIT = 3;
  // Receiver flag register fields
  localparam int RXF_BIT = 0;
  localparam int OVR_BIT = 1;
  localparam int BOFF_BIT = 2;
  localparam int TPAS_BIT = 3;
  localparam int RPAS_BIT = 4;
  localparam int TWRN_BIT = 5;
  localparam int RWRN_BIT = 6;
  localparam int WUP_BIT = 7;
  localparam logic [7:0] ERR_MASK = 8'h7e;
  // Reset values
  localparam logic SOFT_RST = 1'b1;
  localparam logic [2:0] TXE_RST = 3'h7;
  // Error thresholds and bus timing counts
  localparam logic [7:0] WARN_LIMIT = 8'h60;
  localparam logic [8:0] PASS_LIMIT = 9'h07f;
  localparam logic [8:0] BOFF_LIMIT = 9'h0ff;
  localparam logic [3:0] IDLE_BITS = 4'hb;
  localparam logic [6:0] BOFF_GROUPS = 7'h7f;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_SLEEP, MODE_SOFT, MODE_DOWN} mode_t;
  typedef enum logic [1:0] {SLP_AWAKE, SLP_WAIT, SLP_ASLEEP} slp_t;
  // Status reported by the protocol engine, same clock
  typedef struct packed {
    logic rx_frame_ok;
    logic [2:0] tx_done;
    logic tx_busy;
    logic rx_busy;
    logic bit_tick;
    logic [7:0] rx_err;
    logic [8:0] tx_err;
  } engine_t;
  // Controls back to the protocol engine
  typedef struct packed {
    logic core_run;
    logic core_halt;
    logic bus_sync;
    logic [2:0] tx_request;
    logic copy_fg;
    logic boff_recover;
  } engine_ctl_t;
endpackage

// ==== hdl/can_irq_lowpower_control.sv ====
// Interrupt, lock and low-power sequencing of the CAN controller
`timescale 1ns/1ps
`default_nettype none
module can_irq_lowpower_control (
  input wire logic clock, // 25 MHz
  input wire logic resetn, // Async, active low
  input wire logic [7:0] addr, // Register byte address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata_q, // Read data, cycle after rd
  input wire logic cpu_stop, // Processor stop mode
  input wire can_irq_pkg::engine_t eng, // Engine status
  input wire logic can_tx_core, // Engine transmit bit
  input wire logic can_rx, // Receive pin
  output logic can_tx_q, // Transmit pin
  output can_irq_pkg::engine_ctl_t ctl_q, // Engine controls
  output logic irq_wakeup_q, // Wakeup request
  output logic irq_error_q, // Error request
  output logic irq_rx_q, // Receive request
  output logic irq_tx_q // Transmit request
);
  logic rx_s1_q, rx_s2_q, dominant;
  logic sleep_req_q, soft_q, wuen_q, bg_full_q, resync_q;
  logic [7:0] rflag_q, rflag_d, rset, ren_q, rclr;
  logic [2:0] txe_q, ten_q;
  localparam int CFG_NUM_L = can_irq_pkg::CFG_NUM;
  logic [7:0] cfg_q [CFG_NUM_L];
  logic [3:0] bit_cnt_q;
  logic [6:0] boff_cnt_q;
  can_irq_pkg::slp_t slp_q;
  can_irq_pkg::mode_t mode;
  logic sleep_ack, acc, run, busy, wake, bus_wake, group;
  logic is_cfg, copy, rx_new, boff;
  logic [3:0] cfg_idx;

  // ****************************************
  // Pin synchroniser
  // ****************************************
  // Receive pin is asynchronous to the clock
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= can_rx;
      rx_s2_q <= rx_s1_q;
    end
  end
  assign dominant = ~rx_s2_q;

  // ****************************************
  // Mode decode
  // ****************************************
  assign sleep_ack = (slp_q == can_irq_pkg::SLP_ASLEEP);
  // Stop wins over every other bit
  always_comb begin
    if (cpu_stop) begin
      mode = can_irq_pkg::MODE_DOWN;
    end else begin
      case ({sleep_ack, soft_q})
        2'b10: mode = can_irq_pkg::MODE_SLEEP;
        2'b00: mode = can_irq_pkg::MODE_NORMAL;
        default: mode = can_irq_pkg::MODE_SOFT;
      endcase
    end
  end
  assign acc = ~cpu_stop;
  assign run = (mode == can_irq_pkg::MODE_NORMAL);
  assign busy = eng.tx_busy | eng.rx_busy | ~&txe_q;
  assign bus_wake = sleep_ack & dominant;
  assign wake = bus_wake | ~sleep_req_q | soft_q;
  assign boff = eng.tx_err > can_irq_pkg::BOFF_LIMIT;
  assign is_cfg = (addr >= can_irq_pkg::CFG_BASE) &&
    (addr < can_irq_pkg::CFG_BASE + 8'(CFG_NUM_L));
  assign cfg_idx = addr[3:0];

  // ****************************************
  // Control register
  // ****************************************
  // Request clear only takes effect once asleep
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sleep_req_q <= 1'b0;
      soft_q <= can_irq_pkg::SOFT_RST;
      wuen_q <= 1'b0;
    end else begin
      if (wr && acc && addr == can_irq_pkg::CTRL_ADDR) begin
        soft_q <= wdata[can_irq_pkg::SOFT_BIT];
        wuen_q <= wdata[can_irq_pkg::WUEN_BIT];
        if (wdata[can_irq_pkg::SREQ_BIT]) begin
          sleep_req_q <= 1'b1;
        end else if (sleep_ack) begin
          sleep_req_q <= 1'b0;
        end
      end
      // Bus wake drops the request so sleep is not re-entered
      if (bus_wake) begin
        sleep_req_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Sleep handshake
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      slp_q <= can_irq_pkg::SLP_AWAKE;
    end else begin
      case (slp_q)
        can_irq_pkg::SLP_AWAKE: begin
          if (sleep_req_q && !soft_q) begin
            slp_q <= can_irq_pkg::SLP_WAIT;
          end
        end
        // Pending sends and the current frame finish first
        can_irq_pkg::SLP_WAIT: begin
          if (!sleep_req_q || soft_q) begin
            slp_q <= can_irq_pkg::SLP_AWAKE;
          end else if (!busy) begin
            slp_q <= can_irq_pkg::SLP_ASLEEP;
          end
        end
        can_irq_pkg::SLP_ASLEEP: begin
          if (wake) begin
            slp_q <= can_irq_pkg::SLP_AWAKE;
          end
        end
        default: slp_q <= can_irq_pkg::SLP_AWAKE;
      endcase
    end
  end

  // ****************************************
  // Bus idle and bus-off counting
  // ****************************************
  // Counts only while the core runs, so sleep freezes it
  assign group = run & eng.bit_tick & ~dominant &
    (bit_cnt_q == can_irq_pkg::IDLE_BITS - 4'h1);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_q <= 4'h0;
    end else if (run && eng.bit_tick) begin
      if (dominant || group) begin
        bit_cnt_q <= 4'h0;
      end else begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
  end
  // Halted or woken core must see the idle count, frozen while stopped, reach 11 again
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      resync_q <= 1'b1;
    end else if (!run || (sleep_ack && wake)) begin
      resync_q <= 1'b1;
    end else if (group) begin
      resync_q <= 1'b0;
    end
  end
  // Progress is kept across sleep, lost only on leaving bus-off
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      boff_cnt_q <= 7'h0;
    end else if (!boff) begin
      boff_cnt_q <= 7'h0;
    end else if (group) begin
      boff_cnt_q <= boff_cnt_q + 7'h1;
    end
  end

  // ****************************************
  // Receive buffers and flags
  // ****************************************
  assign rx_new = eng.rx_frame_ok & run & ~resync_q;
  // Background to foreground copy waits for a running core
  assign copy = bg_full_q & ~rflag_q[can_irq_pkg::RXF_BIT] & run;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bg_full_q <= 1'b0;
    end else if (copy) begin
      bg_full_q <= 1'b0;
    end else if (rx_new && rflag_q[can_irq_pkg::RXF_BIT]) begin
      bg_full_q <= 1'b1;
    end
  end
  // Level conditions re-set every cycle, so clears lose to them
  always_comb begin
    rset = 8'h0;
    rset[can_irq_pkg::WUP_BIT] = sleep_ack & wuen_q & dominant;
    rset[can_irq_pkg::RWRN_BIT] = eng.rx_err >= can_irq_pkg::WARN_LIMIT;
    rset[can_irq_pkg::TWRN_BIT] =
      eng.tx_err >= {1'b0, can_irq_pkg::WARN_LIMIT};
    rset[can_irq_pkg::RPAS_BIT] =
      {1'b0, eng.rx_err} > can_irq_pkg::PASS_LIMIT;
    rset[can_irq_pkg::TPAS_BIT] = eng.tx_err > can_irq_pkg::PASS_LIMIT;
    rset[can_irq_pkg::BOFF_BIT] = boff;
    rset[can_irq_pkg::OVR_BIT] =
      rx_new & rflag_q[can_irq_pkg::RXF_BIT] & bg_full_q;
    rset[can_irq_pkg::RXF_BIT] =
      copy | (rx_new & ~rflag_q[can_irq_pkg::RXF_BIT]);
    rclr = (wr && acc && addr == can_irq_pkg::RFLG_ADDR) ? wdata : 8'h0;
    rflag_d = (rflag_q & ~rclr) | rset;
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rflag_q <= 8'h0;
    end else begin
      rflag_q <= rflag_d;
    end
  end

  // ****************************************
  // Transmit flags and enables
  // ****************************************
  // Clearing an empty flag schedules the buffer; completion wins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txe_q <= can_irq_pkg::TXE_RST;
    end else begin
      txe_q <= (txe_q & ~((wr && acc && addr == can_irq_pkg::TFLG_ADDR) ?
        wdata[2:0] : 3'h0)) | eng.tx_done;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ren_q <= 8'h0;
      ten_q <= 3'h0;
    end else if (wr && acc) begin
      if (addr == can_irq_pkg::RIEN_ADDR) begin
        ren_q <= wdata;
      end
      if (addr == can_irq_pkg::TIEN_ADDR) begin
        ten_q <= wdata[2:0];
      end
    end
  end

  // ****************************************
  // Locked configuration
  // ****************************************
  // Timing and filter settings only change off-line
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < CFG_NUM_L; i++) begin
        cfg_q[i] <= 8'h0;
      end
    end else if (wr && acc && is_cfg && soft_q) begin
      cfg_q[cfg_idx] <= wdata;
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  // Counters appear only here, there is no write path
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h0;
    end else if (!rd || !acc) begin
      rdata_q <= 8'h0;
    end else if (is_cfg) begin
      rdata_q <= cfg_q[cfg_idx];
    end else begin
      case (addr)
        can_irq_pkg::CTRL_ADDR:
          rdata_q <= {4'h0, wuen_q, sleep_ack, soft_q, sleep_req_q};
        can_irq_pkg::RFLG_ADDR: rdata_q <= rflag_q;
        can_irq_pkg::RIEN_ADDR: rdata_q <= ren_q;
        can_irq_pkg::TFLG_ADDR: rdata_q <= {5'h0, txe_q};
        can_irq_pkg::TIEN_ADDR: rdata_q <= {5'h0, ten_q};
        can_irq_pkg::STAT_ADDR: rdata_q <= {3'h0, bg_full_q, resync_q,
          slp_q == can_irq_pkg::SLP_WAIT, mode};
        can_irq_pkg::RXERR_ADDR: rdata_q <= eng.rx_err;
        can_irq_pkg::TXERR_ADDR: rdata_q <= eng.tx_err[7:0];
        default: rdata_q <= 8'h0;
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // One flop of delay keeps every output glitch free
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      can_tx_q <= 1'b1;
      ctl_q <= '0;
      irq_wakeup_q <= 1'b0;
      irq_error_q <= 1'b0;
      irq_rx_q <= 1'b0;
      irq_tx_q <= 1'b0;
    end else begin
      can_tx_q <= run ? can_tx_core : 1'b1;
      ctl_q.core_run <= run;
      ctl_q.core_halt <= soft_q | cpu_stop;
      ctl_q.bus_sync <= run & ~resync_q;
      ctl_q.tx_request <= ~txe_q & {3{run & ~resync_q}};
      ctl_q.copy_fg <= copy;
      ctl_q.boff_recover <= group & boff &
        (boff_cnt_q == can_irq_pkg::BOFF_GROUPS);
      irq_wakeup_q <= rflag_q[can_irq_pkg::WUP_BIT] &
        ren_q[can_irq_pkg::WUP_BIT];
      irq_error_q <= |(rflag_q & ren_q & can_irq_pkg::ERR_MASK);
      irq_rx_q <= rflag_q[can_irq_pkg::RXF_BIT] &
        ren_q[can_irq_pkg::RXF_BIT];
      irq_tx_q <= |(txe_q & ten_q);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  // Flags and irqs are registered, so checks look one cycle on per register stage
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  tx_recessive_a: assert property (!run |=> can_tx_q)
    else $error("tx pin not recessive in low power");
  tx_irq_a: assert property (
    irq_tx_q == |($past(txe_q) & $past(ten_q)))
    else $error("tx irq does not follow enabled empty flags");
  rx_irq_a: assert property (
    rx_new && !rflag_q[can_irq_pkg::RXF_BIT] && ren_q[can_irq_pkg::RXF_BIT]
    |=> ##1 irq_rx_q)
    else $error("rx irq missing after frame");
  warn_hold_a: assert property (
    eng.rx_err >= can_irq_pkg::WARN_LIMIT |=> rflag_q[can_irq_pkg::RWRN_BIT])
    else $error("rx warning flag not set");
  passive_a: assert property (
    eng.tx_err > can_irq_pkg::PASS_LIMIT |=> rflag_q[can_irq_pkg::TPAS_BIT])
    else $error("tx passive flag not set");
  bus_off_a: assert property (
    boff |=> rflag_q[can_irq_pkg::BOFF_BIT] ##1
    (irq_error_q || !ren_q[can_irq_pkg::BOFF_BIT]))
    else $error("bus off flag or irq missing");
  req_hold_a: assert property (
    wr && acc && addr == can_irq_pkg::CTRL_ADDR &&
    !wdata[can_irq_pkg::SREQ_BIT] && sleep_req_q && !sleep_ack
    |=> sleep_req_q)
    else $error("sleep request cleared before ack");
  // Entry must be prompt once idle, and the pin must follow one cycle after the acknowledge
  sleep_entry_a: assert property (
    slp_q == can_irq_pkg::SLP_WAIT && sleep_req_q && !soft_q && !busy
    |=> sleep_ack ##1 can_tx_q)
    else $error("sleep not entered when idle");
  copy_defer_a: assert property (
    sleep_ack && $past(sleep_ack) |-> !ctl_q.copy_fg)
    else $error("copy during sleep");
  resync_a: assert property (
    sleep_ack && wake |=> resync_q ##1 !ctl_q.bus_sync)
    else $error("no resync after wakeup");
  err_irq_a: assert property (
    irq_error_q == |($past(rflag_q) & $past(ren_q) & can_irq_pkg::ERR_MASK))
    else $error("error irq does not follow enabled flags");
  wake_flag_a: assert property (
    sleep_ack && wuen_q && dominant |=> rflag_q[can_irq_pkg::WUP_BIT])
    else $error("wakeup flag not set on bus activity");
  bus_wake_a: assert property (
    bus_wake |=> !sleep_ack && !sleep_req_q)
    else $error("bus activity did not end sleep");
  soft_halt_a: assert property (soft_q |=> ctl_q.core_halt)
    else $error("engine not halted in soft reset");
  down_read_a: assert property (rd && cpu_stop |=> rdata_q == 8'h00)
    else $error("register readable in power-down");
  boff_hold_a: assert property (!run && boff |=> $stable(boff_cnt_q))
    else $error("bus-off recovery count moved while stopped");
  // Counter read must show the engine's count, untouched by writes
  err_count_a: assert property (
    rd && acc && addr == can_irq_pkg::RXERR_ADDR
    |=> rdata_q == $past(eng.rx_err))
    else $error("rx error count not shown as counted");
  sleep_c: cover property (slp_q == can_irq_pkg::SLP_WAIT ##1 sleep_ack);
  bus_wake_c: cover property (bus_wake ##1 !sleep_ack);
  overrun_c: cover property (rset[can_irq_pkg::OVR_BIT]);
  soft_wake_c: cover property (sleep_ack && soft_q ##1 !sleep_ack);
  power_down_c: cover property (mode == can_irq_pkg::MODE_DOWN ##1 run);
endmodule // can_irq_lowpower_control
`default_nettype wire

// ==== sim/can_engine_model.sv ====
// Behavioural protocol engine on the far side of the irq/power block
`timescale 1ns/1ps
`default_nettype none
module can_engine_model (
  input wire logic clock, // Module clock
  input wire logic resetn, // Async, active low
  input wire can_irq_pkg::engine_ctl_t ctl, // Controls from block
  output can_irq_pkg::engine_t eng // Status to block
);
  logic frame, busy, tick;
  logic [1:0] rest;
  logic [2:0] done, sel, pick;
  logic [1:0] tcnt;
  logic [4:0] cnt;
  logic [7:0] rerr;
  logic [8:0] terr;
  // Lowest scheduled buffer goes first
  assign pick = ctl.tx_request[0] ? 3'h1 :
    ctl.tx_request[1] ? 3'h2 : {ctl.tx_request[2], 2'h0};
  assign eng = {frame, done, busy, 1'b0, tick, rerr, terr};
  initial begin
    frame = 1'b0;
    rerr = 8'h00;
    terr = 9'h000;
  end
  // A bit time of four clocks keeps the resync wait short
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tcnt <= 2'h0;
      tick <= 1'b0;
    end else begin
      tcnt <= tcnt + 2'h1;
      tick <= (tcnt == 2'h3);
    end
  end
  // A send lasts 32 clocks; rest skips the two cycles of stale request
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      rest <= 2'h0;
      cnt <= 5'h00;
      done <= 3'h0;
      sel <= 3'h0;
    end else begin
      done <= 3'h0;
      rest <= rest >> 1;
      if (busy && ctl.core_halt) begin
        busy <= 1'b0;
      end else if (busy) begin
        cnt <= cnt + 5'h01;
        if (cnt == 5'h1f) begin
          busy <= 1'b0;
          done <= sel;
          rest <= 2'h3;
        end
      end else if (ctl.core_run && rest == 2'h0 && (pick != 3'h0)) begin
        busy <= 1'b1;
        sel <= pick;
        cnt <= 5'h00;
      end
    end
  end
  // Error counters are owned here, never by software
  task automatic set_err(input logic [7:0] r, input logic [8:0] t);
    rerr = r;
    terr = t;
  endtask
  // One good frame at end of frame
  task automatic pulse_frame();
    @(posedge clock);
    frame <= 1'b1;
    @(posedge clock);
    frame <= 1'b0;
  endtask
endmodule // can_engine_model
`default_nettype wire

// ==== sim/can_irq_lowpower_control_test.sv ====
// Register-level bench of the CAN irq/power block
`timescale 1ns/1ps
`default_nettype none
module can_irq_lowpower_control_test;
  localparam logic [7:0] CT = can_irq_pkg::CTRL_ADDR;
  localparam logic [7:0] RF = can_irq_pkg::RFLG_ADDR;
  localparam logic [7:0] RE = can_irq_pkg::RIEN_ADDR;
  localparam logic [7:0] TF = can_irq_pkg::TFLG_ADDR;
  localparam logic [7:0] TE = can_irq_pkg::TIEN_ADDR;
  localparam logic [7:0] ST = can_irq_pkg::STAT_ADDR;
  localparam logic [7:0] RX = can_irq_pkg::RXERR_ADDR;
  localparam logic [7:0] CF = can_irq_pkg::CFG_BASE;
  logic clock = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic cpu_stop = 1'b0, can_tx_core = 1'b1, can_rx = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata_q;
  logic can_tx_q, irq_wakeup_q, irq_error_q, irq_rx_q, irq_tx_q;
  can_irq_pkg::engine_t eng;
  can_irq_pkg::engine_ctl_t ctl_q;
  int fails = 0, n_tests = 0, cycles = 0, i;
  // Error counter cases around 96, 127 and 255
  logic [7:0] tr [8] = '{8'h5f, 8'h60, 8'h7f, 8'h80, 0, 0, 0, 0};
  logic [8:0] tt [8] = '{0, 0, 0, 0, 9'h060, 9'h080, 9'h0ff, 9'h100};
  logic [7:0] te [8] = '{0, 8'h40, 8'h40, 8'h50, 8'h20, 8'h28, 8'h28, 8'h2c};
  always #20 clock = ~clock;
  can_irq_lowpower_control uut (.clock(clock), .resetn(resetn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
    .cpu_stop(cpu_stop), .eng(eng), .can_tx_core(can_tx_core),
    .can_rx(can_rx), .can_tx_q(can_tx_q), .ctl_q(ctl_q),
    .irq_wakeup_q(irq_wakeup_q), .irq_error_q(irq_error_q),
    .irq_rx_q(irq_rx_q), .irq_tx_q(irq_tx_q));
  can_engine_model m (.clock(clock), .resetn(resetn), .ctl(ctl_q),
    .eng(eng));
  // ****************************
  // Tasks
  // ****************************
  task automatic report_and_stop();
    $display("tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, m, e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata_q & m, e);
  endtask
  // Bounded poll of one register bit
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    for (int k = 0; k < 100; k++) begin
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 if (rdata_q[b] === v) break;
    end
    chk(rdata_q[b], v);
  endtask
  // Hang guard well above the expected few hundred cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  // ****************************
  // Main sequence
  // ****************************
  initial begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    rc(CT, 8'h0f, 8'h02);
    rc(TF, 8'h07, 8'h07);
    rc(ST, 8'h03, 8'h02);
    chk(can_tx_q, 1'b1);
    wr_reg(CF, 8'h5a);
    rc(CF, 8'hff, 8'h5a);
    wr_reg(CT, 8'h00);
    wr_reg(CF, 8'ha5);
    rc(CF, 8'hff, 8'h5a);
    m.set_err(8'h21, 9'h000);
    wr_reg(RX, 8'hff);
    rc(RX, 8'hff, 8'h21);
    m.set_err(8'h00, 9'h000);
    wait_bit(ST, 3, 1'b0);
    rc(ST, 8'h03, 8'h00);
    chk(ctl_q.bus_sync, 1'b1);
    @(posedge clock);
    can_tx_core <= 1'b0;
    repeat (3) @(posedge clock);
    #1 chk(can_tx_q, 1'b0);
    // Error thresholds, enables and write-one-to-clear
    wr_reg(RE, 8'hff);
    for (i = 0; i < 8; i++) begin
      m.set_err(tr[i], tt[i]);
      repeat (3) @(posedge clock);
      rc(RF, 8'h7e, te[i]);
      chk(irq_error_q, te[i] != 8'h00);
      wr_reg(RF, 8'h7e);
      rc(RF, 8'h7e, te[i]);
      m.set_err(8'h00, 9'h000);
      repeat (2) @(posedge clock);
      wr_reg(RF, 8'h7e);
      rc(RF, 8'h7e, 8'h00);
      chk(irq_error_q, 1'b0);
    end
    // Receive frame, then background fill and overrun
    m.pulse_frame();
    repeat (3) @(posedge clock);
    rc(RF, 8'h01, 8'h01);
    chk(irq_rx_q, 1'b1);
    m.pulse_frame();
    m.pulse_frame();
    rc(RF, 8'h03, 8'h03);
    rc(ST, 8'h10, 8'h10);
    chk(irq_error_q, 1'b1);
    wr_reg(RF, 8'h01);
    rc(RF, 8'h03, 8'h03);
    rc(ST, 8'h10, 8'h00);
    wr_reg(RF, 8'h03);
    rc(RF, 8'h01, 8'h00);
    chk(irq_rx_q, 1'b0);
    // Sleep requested while sending
    wr_reg(TE, 8'h02);
    wr_reg(TF, 8'h02);
    rc(TF, 8'h07, 8'h05);
    chk(irq_tx_q, 1'b0);
    wr_reg(CT, 8'h01);
    wr_reg(CT, 8'h00);
    rc(CT, 8'h07, 8'h01);
    wait_bit(CT, 2, 1'b1);
    rc(TF, 8'h07, 8'h07);
    chk(irq_tx_q, 1'b1);
    rc(ST, 8'h03, 8'h01);
    chk(can_tx_q, 1'b1);
    chk(ctl_q.core_run, 1'b0);
    wr_reg(CT, 8'h00);
    wait_bit(CT, 2, 1'b0);
    rc(ST, 8'h03, 8'h00);
    // Power-down: no access, pin recessive
    @(posedge clock);
    cpu_stop <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk(can_tx_q, 1'b1);
    chk(ctl_q.core_halt, 1'b1);
    rc(TE, 8'hff, 8'h00);
    wr_reg(TE, 8'h00);
    cpu_stop <= 1'b0;
    rc(TE, 8'h07, 8'h02);
    // Wake by bus activity
    wr_reg(CT, 8'h09);
    wait_bit(CT, 2, 1'b1);
    @(posedge clock);
    can_rx <= 1'b0;
    wait_bit(RF, 7, 1'b1);
    chk(irq_wakeup_q, 1'b1);
    rc(CT, 8'h05, 8'h00);
    rc(ST, 8'h08, 8'h08);
    chk(ctl_q.bus_sync, 1'b0);
    @(posedge clock);
    can_rx <= 1'b1;
    // Wake by soft reset
    wr_reg(CT, 8'h01);
    wait_bit(CT, 2, 1'b1);
    wr_reg(CT, 8'h03);
    wait_bit(CT, 2, 1'b0);
    rc(ST, 8'h03, 8'h02);
    report_and_stop();
  end
endmodule // can_irq_lowpower_control_test
`default_nettype wire
